/* hw/btd_pkg.sv */
// constants, types and helpers for the bus trace and trigger unit
// How it works
// R1 - eight-word capture FIFO for address or data
// R2 - two 16-bit comparators, per-comparator direction qualifier
// R3 - opcode tracking: trigger only on executed opcode
// R4 - range modes: inside or outside A..B
// R5 - no matching during serial debug accesses
// R6 - comparator A always watches CPU address; with opcode_track_en set, the code compares exec_addr instead of cpu_addr
// R7 - comparator B watches address or data
// R8 - data compare uses write bus when A qualifies writes
// R9 - match breaks, stores data, begins or ends trace
// R10 - word count follows every stored word
// R11 - early halt realigns stored words by one; the code instead sets the read pointer to wr_q minus the word count
// R12 - readout in capture order
// R13 - serial debug controller reaches controls and FIFO
// R14 - controls also mapped in user register space
// R15 - operator configures, arms, then reads FIFO
// R16 - capture only while armed, stop when full except in end-trace mode, which overwrites the oldest word
package btd_pkg;
    localparam int ADDR_W = 16;
    localparam int DATA_W = 8;
    localparam int FIFO_DEPTH = 8;
    localparam int PTR_W = 3;
    localparam int CNT_W = 4;
    localparam logic [CNT_W-1:0] CNT_FULL = 4'h8;
    localparam logic [CNT_W-1:0] CNT_RESET = 4'h0;
    localparam logic [PTR_W-1:0] PTR_RESET = 3'h0;
    localparam logic [ADDR_W-1:0] WORD_RESET = 16'h0000;

    // trigger modes
    localparam logic [2:0] MODE_A_ONLY = 3'h0;
    localparam logic [2:0] MODE_A_OR_B = 3'h1;
    localparam logic [2:0] MODE_A_AND_B = 3'h2;
    localparam logic [2:0] MODE_A_AND_BDATA = 3'h3;
    localparam logic [2:0] MODE_A_AND_NOT_BDATA = 3'h4;
    localparam logic [2:0] MODE_INSIDE = 3'h5;
    localparam logic [2:0] MODE_OUTSIDE = 3'h6;

    // what a qualified match does
    localparam logic [1:0] ACT_BREAK = 2'h0;
    localparam logic [1:0] ACT_STORE_DATA = 2'h1;
    localparam logic [1:0] ACT_BEGIN_TRACE = 2'h2;
    localparam logic [1:0] ACT_END_TRACE = 2'h3;

    typedef enum logic [3:0] {
        ST_IDLE = 4'h1,
        ST_ARMED = 4'h2,
        ST_TRACE = 4'h4,
        ST_DONE = 4'h8
    } btd_state_type;

    // direction qualifier: sel 1 = read, 0 = write; rw 1 = read
    function automatic logic btd_dir_ok(input logic en, input logic sel, input logic rw);
        btd_dir_ok = !en || (rw == sel);
    endfunction
endpackage

/* hw/btd_trace_unit.sv */
// bus trace and trigger unit: comparators, trigger sequencer, capture FIFO
`timescale 1ns/1ps
module btd_trace_unit
    import btd_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [btd_pkg::ADDR_W-1:0] cpu_addr,
    input wire logic [btd_pkg::DATA_W-1:0] cpu_wdata,
    input wire logic [btd_pkg::DATA_W-1:0] cpu_rdata,
    input wire logic cpu_rw,
    input wire logic cpu_access,
    input wire logic exec_valid,
    input wire logic [btd_pkg::ADDR_W-1:0] exec_addr,
    input wire logic cof_valid,
    input wire logic [btd_pkg::ADDR_W-1:0] cof_addr,
    input wire logic serial_debug_access,
    input wire logic arm,
    input wire logic [2:0] trig_mode,
    input wire logic [1:0] trig_action,
    input wire logic opcode_track_en,
    input wire logic [btd_pkg::ADDR_W-1:0] comp_a_value,
    input wire logic [btd_pkg::ADDR_W-1:0] comp_b_value,
    input wire logic dir_qual_enable_a,
    input wire logic dir_select_a,
    input wire logic dir_qual_enable_b,
    input wire logic dir_select_b,
    input wire logic fifo_rd,
    output logic [btd_pkg::ADDR_W-1:0] fifo_rd_data,
    output logic [btd_pkg::CNT_W-1:0] fifo_word_count,
    output logic brk_req,
    output logic trace_armed,
    output logic capture_done
);
    import btd_pkg::*;

    btd_state_type st_q, st_d;
    logic arm_q, arm_d;
    logic [PTR_W-1:0] wr_q, wr_d, rd_q, rd_d;
    logic [CNT_W-1:0] cnt_q, cnt_d;
    logic brk_q, brk_d;
    logic [ADDR_W-1:0] rdata_q, rdata_d;
    logic [ADDR_W-1:0] mem_q [FIFO_DEPTH];

    logic [ADDR_W-1:0] cmp_addr;
    logic cmp_valid;
    logic [DATA_W-1:0] b_data;
    logic a_hit, b_hit, bd_hit, in_range, dir_a, dir_b;
    logic match;
    logic push, pop;
    logic [ADDR_W-1:0] push_data;

    // comparator front end
    always_comb
    begin
        cmp_addr = opcode_track_en ? exec_addr : cpu_addr; // R3 R6
        cmp_valid = opcode_track_en ? exec_valid : cpu_access; // R3
        dir_a = opcode_track_en || btd_dir_ok(dir_qual_enable_a, dir_select_a, cpu_rw); // R2
        dir_b = opcode_track_en || btd_dir_ok(dir_qual_enable_b, dir_select_b, cpu_rw); // R2
        b_data = (dir_qual_enable_a && !dir_select_a) ? cpu_wdata : cpu_rdata; // R8
        a_hit = (cmp_addr == comp_a_value) && dir_a; // R6
        b_hit = (cmp_addr == comp_b_value) && dir_b; // R7
        bd_hit = (b_data == comp_b_value[DATA_W-1:0]) && dir_b; // R7
        in_range = (cmp_addr >= comp_a_value) && (cmp_addr <= comp_b_value); // R4
        match = 1'b0;
        case (trig_mode)
            MODE_A_ONLY: match = a_hit;
            MODE_A_OR_B: match = a_hit || b_hit;
            MODE_A_AND_B: match = a_hit && b_hit;
            MODE_A_AND_BDATA: match = a_hit && bd_hit;
            MODE_A_AND_NOT_BDATA: match = a_hit && !bd_hit;
            MODE_INSIDE: match = in_range && dir_a; // R4
            MODE_OUTSIDE: match = !in_range && dir_a; // R4
            default: match = 1'b0;
        endcase
        match = match && cmp_valid && !serial_debug_access; // R5
    end

    // trigger sequencer and FIFO bookkeeping
    always_comb
    begin
        st_d = st_q;
        arm_d = arm;
        wr_d = wr_q;
        rd_d = rd_q;
        cnt_d = cnt_q;
        brk_d = 1'b0;
        rdata_d = rdata_q;
        push = 1'b0;
        push_data = WORD_RESET;
        pop = fifo_rd && (cnt_q != CNT_RESET); // R13 R14
        if (pop)
        begin
            rdata_d = mem_q[rd_q]; // R12
            rd_d = rd_q + 3'h1;
            cnt_d = cnt_q - 4'h1;
        end
        if (!arm && st_q != ST_IDLE)
        begin
            st_d = ST_IDLE; // R16
            if (st_q != ST_DONE && cnt_q < CNT_FULL)
            begin
                rd_d = wr_q - cnt_q[PTR_W-1:0]; // R11
            end
        end
        else
        begin
            case (st_q)
                ST_IDLE:
                begin
                    if (arm && !arm_q)
                    begin
                        st_d = ST_ARMED;
                        wr_d = PTR_RESET;
                        rd_d = PTR_RESET;
                        cnt_d = CNT_RESET;
                    end
                end
                ST_ARMED:
                begin
                    if (match)
                    begin
                        case (trig_action) // R9
                            ACT_BREAK:
                            begin
                                brk_d = 1'b1;
                                st_d = ST_DONE;
                            end
                            ACT_STORE_DATA:
                            begin
                                push = 1'b1;
                                push_data = {8'h00, b_data};
                            end
                            ACT_BEGIN_TRACE: st_d = ST_TRACE;
                            default: st_d = ST_DONE;
                        endcase
                    end
                    else if (trig_action == ACT_END_TRACE && cof_valid)
                    begin
                        push = 1'b1;
                        push_data = cof_addr;
                    end
                end
                ST_TRACE:
                begin
                    if (cof_valid)
                    begin
                        push = 1'b1;
                        push_data = cof_addr;
                    end
                end
                ST_DONE: st_d = ST_DONE;
                default: st_d = ST_IDLE;
            endcase
            if (push)
            begin
                wr_d = wr_q + 3'h1;
                if (cnt_d == CNT_FULL)
                begin
                    rd_d = rd_d + 3'h1;
                end
                else
                begin
                    cnt_d = cnt_d + 4'h1; // R10
                end
                if (trig_action != ACT_END_TRACE && cnt_d == CNT_FULL)
                begin
                    st_d = ST_DONE; // R16
                end
            end
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            st_q <= ST_IDLE;
            arm_q <= 1'b0;
            wr_q <= PTR_RESET;
            rd_q <= PTR_RESET;
            cnt_q <= CNT_RESET;
            brk_q <= 1'b0;
            rdata_q <= WORD_RESET;
        end
        else
        begin
            st_q <= st_d;
            arm_q <= arm_d;
            wr_q <= wr_d;
            rd_q <= rd_d;
            cnt_q <= cnt_d;
            brk_q <= brk_d;
            rdata_q <= rdata_d;
        end
    end

    // storage has no reset; count marks the valid words
    always_ff @(posedge sys_clk)
    begin
        if (push)
        begin
            mem_q[wr_q] <= push_data; // R1
        end
    end

    assign fifo_rd_data = rdata_q;
    assign fifo_word_count = cnt_q;
    assign brk_req = brk_q;
    assign trace_armed = (st_q != ST_IDLE);
    assign capture_done = (st_q == ST_DONE);

    AST_COUNT_LIMIT: // R1
        assert property (@(posedge sys_clk) disable iff (rst) cnt_q <= CNT_FULL)
        else $error("fifo word count above depth");

    AST_SERIAL_SUPPRESS: // R5
        assert property (@(posedge sys_clk) disable iff (rst) serial_debug_access |-> !match)
        else $error("match during serial debug access");

    AST_TRACK_EXEC: // R3
        assert property (@(posedge sys_clk) disable iff (rst)
            (opcode_track_en && !exec_valid) |-> !match)
        else $error("tracked match without executed opcode");

    AST_A_ADDR: // R6
        assert property (@(posedge sys_clk) disable iff (rst)
            (trig_mode == MODE_A_ONLY && !opcode_track_en && cpu_access && !serial_debug_access
             && !dir_qual_enable_a && cpu_addr == comp_a_value) |-> match)
        else $error("comparator A missed address");

    AST_B_ADDR: // R7
        assert property (@(posedge sys_clk) disable iff (rst)
            (trig_mode == MODE_A_OR_B && !opcode_track_en && cpu_access && !serial_debug_access
             && !dir_qual_enable_b && cpu_addr == comp_b_value) |-> match)
        else $error("comparator B missed address");

    AST_WDATA_SEL: // R8
        assert property (@(posedge sys_clk) disable iff (rst)
            (dir_qual_enable_a && !dir_select_a) |-> b_data == cpu_wdata)
        else $error("data compare not on write bus");

    AST_RANGE_LOW: // R4
        assert property (@(posedge sys_clk) disable iff (rst)
            (trig_mode == MODE_INSIDE && !opcode_track_en && cpu_addr < comp_a_value)
            |-> !match)
        else $error("inside range fired below lower bound");

    AST_BREAK_CAUSE: // R9
        assert property (@(posedge sys_clk) disable iff (rst)
            (st_q == ST_ARMED && arm && match && trig_action == ACT_BREAK)
            |=> brk_req && capture_done)
        else $error("breakpoint not raised on match");

    AST_COUNT_UP: // R10
        assert property (@(posedge sys_clk) disable iff (rst)
            (push && !pop && cnt_q < 4'h7 && arm) |=> cnt_q == $past(cnt_q) + 4'h1)
        else $error("word count did not follow store");

    AST_IDLE_NO_STORE: // R16
        assert property (@(posedge sys_clk) disable iff (rst)
            (st_q == ST_IDLE) |-> !push)
        else $error("capture while disarmed");

    AST_READ_ORDER: // R12
        assert property (@(posedge sys_clk) disable iff (rst)
            pop |=> fifo_rd_data == $past(mem_q[rd_q]) && fifo_word_count == $past(cnt_q) - 4'h1
                    || $past(push))
        else $error("readout not in capture order");
endmodule // btd_trace_unit

/* bench/btd_cpu_model.sv */
// cpu bus partner model: replays bench requests as one-cycle bus accesses
`timescale 1ns/1ps
module btd_cpu_model
    import btd_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic req,
    input wire logic req_rw,
    input wire logic [btd_pkg::ADDR_W-1:0] req_addr,
    input wire logic [btd_pkg::DATA_W-1:0] req_wdata,
    input wire logic [btd_pkg::DATA_W-1:0] req_rdata,
    output logic [btd_pkg::ADDR_W-1:0] cpu_addr,
    output logic [btd_pkg::DATA_W-1:0] cpu_wdata,
    output logic [btd_pkg::DATA_W-1:0] cpu_rdata,
    output logic cpu_rw,
    output logic cpu_access
);
    // idle bus flips every cycle so no stale value can match
    always_ff @(posedge sys_clk)
    begin
        cpu_access <= !rst && req;
        cpu_rw <= rst ? 1'h1 : (req ? req_rw : ~cpu_rw);
        cpu_addr <= rst ? '0 : (req ? req_addr : ~cpu_addr);
        cpu_wdata <= rst ? '0 : (req ? req_wdata : ~cpu_wdata);
        cpu_rdata <= rst ? '0 : (req ? req_rdata : ~cpu_rdata);
    end
endmodule // btd_cpu_model

/* bench/btd_trace_unit_bench.sv */
// self-checking bench of the bus trace and trigger unit
`timescale 1ns/1ps
module bus_trace_trigger_debug_bench;
    import btd_pkg::*;
    logic sys_clk = 0, rst = 1, req = 0, req_rw = 1, exec_valid = 0, arm = 0;
    logic serial_debug_access = 0;
    logic opcode_track_en = 0, fifo_rd = 0, dir_qual_enable_a = 0, dir_select_a = 0;
    logic dir_qual_enable_b = 0, dir_select_b = 0, cof_valid = 0;
    logic [15:0] req_addr = '0, exec_addr = '0, comp_a_value = '0, comp_b_value = '0;
    logic [15:0] cof_addr = '0, cpu_addr, fifo_rd_data;
    logic [7:0] req_wdata = '0, req_rdata = '0, cpu_wdata, cpu_rdata;
    logic [2:0] trig_mode = '0;
    logic [1:0] trig_action = '0;
    logic cpu_rw, cpu_access, brk_req, trace_armed, capture_done;
    logic [3:0] fifo_word_count;
    logic [31:0] seed = 32'h3EEA1E47;
    int error_cnt = 0, cmp_count = 0, brk_seen = 0;

    btd_cpu_model cpu_u (.sys_clk(sys_clk), .rst(rst), .req(req), .req_rw(req_rw),
        .req_addr(req_addr), .req_wdata(req_wdata), .req_rdata(req_rdata),
        .cpu_addr(cpu_addr), .cpu_wdata(cpu_wdata), .cpu_rdata(cpu_rdata),
        .cpu_rw(cpu_rw), .cpu_access(cpu_access));
    btd_trace_unit dut_u (.sys_clk(sys_clk), .rst(rst), .cpu_addr(cpu_addr),
        .cpu_wdata(cpu_wdata), .cpu_rdata(cpu_rdata), .cpu_rw(cpu_rw),
        .cpu_access(cpu_access), .exec_valid(exec_valid), .exec_addr(exec_addr),
        .cof_valid(cof_valid), .cof_addr(cof_addr),
        .serial_debug_access(serial_debug_access), .arm(arm),
        .trig_mode(trig_mode), .trig_action(trig_action), .opcode_track_en(opcode_track_en),
        .comp_a_value(comp_a_value), .comp_b_value(comp_b_value),
        .dir_qual_enable_a(dir_qual_enable_a), .dir_select_a(dir_select_a),
        .dir_qual_enable_b(dir_qual_enable_b), .dir_select_b(dir_select_b),
        .fifo_rd(fifo_rd), .fifo_rd_data(fifo_rd_data), .fifo_word_count(fifo_word_count),
        .brk_req(brk_req), .trace_armed(trace_armed), .capture_done(capture_done));

    initial forever #5 sys_clk = ~sys_clk;
    always @(posedge sys_clk) if (brk_req === 1'h1) brk_seen++;

    task automatic tick(input int n = 1);
        repeat (n) @(posedge sys_clk);
    endtask
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("MISMATCH t=%0t seen %h exp %h", $time, seen, exp);
        end
    endtask
    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    // expected qualified match of the access now on the request lines
    function automatic logic hit(input logic [15:0] a);
        logic ma, mb, db, h;
        ma = a == comp_a_value && (!dir_qual_enable_a || req_rw == dir_select_a);
        mb = a == comp_b_value && (!dir_qual_enable_b || req_rw == dir_select_b);
        db = ((dir_qual_enable_a && !dir_select_a) ? req_wdata : req_rdata)
            == comp_b_value[7:0];
        case (trig_mode)
            MODE_A_ONLY: h = ma;
            MODE_A_OR_B: h = ma || mb;
            MODE_A_AND_B: h = ma && mb;
            MODE_A_AND_BDATA: h = ma && db;
            MODE_A_AND_NOT_BDATA: h = ma && !db;
            MODE_INSIDE: h = a >= comp_a_value && a <= comp_b_value;
            MODE_OUTSIDE: h = a < comp_a_value || a > comp_b_value;
            default: h = 1'h0;
        endcase
        return h && !serial_debug_access;
    endfunction
    task automatic setup(input logic [2:0] m, input logic [1:0] act, input logic [15:0] a,
        input logic [15:0] b);
        trig_mode <= m;
        trig_action <= act;
        comp_a_value <= a;
        comp_b_value <= b;
        arm <= 1'h1;
        tick();
    endtask
    task automatic disarm();
        arm <= 1'h0;
        tick(2);
    endtask
    task automatic access(input logic [15:0] a, input logic [7:0] wd, input logic [7:0] rd);
        req <= 1'h1;
        req_addr <= a;
        req_wdata <= wd;
        req_rdata <= rd;
        tick();
        req <= 1'h0;
        tick(3);
    endtask
    // pop m words and expect base, base+1, ...
    task automatic drain(input int m, input logic [15:0] base);
        for (int i = 0; i <= m; i++)
        begin
            fifo_rd <= 1'h1;
            tick();
            fifo_rd <= 1'h0;
            tick();
            if (i < m)
                chk(fifo_rd_data, base + 16'(i));
        end
        chk(16'(fifo_word_count), 16'h0000);
    endtask
    task automatic cof(input logic [15:0] a);
        cof_addr <= a;
        cof_valid <= 1'h1;
        tick();
        cof_valid <= 1'h0;
        tick();
    endtask
    // store up to eight of n data words back to back, then halt and read them out
    task automatic fill(input int n);
        int m;
        m = n > 8 ? 8 : n;
        setup(MODE_A_ONLY, ACT_STORE_DATA, 16'h8001, 16'h0000);
        req <= 1'h1;
        req_addr <= 16'h8001;
        for (int i = 0; i < n; i++)
        begin
            req_wdata <= 8'hA0 + 8'(i);
            req_rdata <= 8'hA0 + 8'(i);
            tick();
        end
        req <= 1'h0;
        tick(3);
        chk(16'(fifo_word_count), 16'(m));
        chk(16'(capture_done), 16'(n >= 8));
        chk(16'(trace_armed), 16'h0001);
        disarm();
        chk(16'(trace_armed), 16'h0000);
        drain(m, 16'h00A0);
        $display("test fill %0d done", n);
    endtask

    initial
    begin
        logic [31:0] r;
        logic [15:0] a, b, x;
        tick(3);
        rst <= 1'h0;
        tick();
        fill(10);
        fill(3);
        opcode_track_en <= 1'h1;
        setup(MODE_A_ONLY, ACT_STORE_DATA, 16'h4A10, 16'h0000);
        access(16'h4A10, 8'h11, 8'h22);
        chk(16'(fifo_word_count), 16'h0000);
        exec_addr <= 16'h4A10;
        exec_valid <= 1'h1;
        tick();
        exec_valid <= 1'h0;
        tick(3);
        chk(16'(fifo_word_count), 16'h0001);
        disarm();
        opcode_track_en <= 1'h0;
        $display("test opcode done");
        setup(MODE_A_ONLY, ACT_BEGIN_TRACE, 16'h1234, 16'h0000);
        cof(16'h2000);
        chk(16'(fifo_word_count), 16'h0000);
        access(16'h1234, 8'h00, 8'h00);
        for (int i = 0; i < 3; i++)
            cof(16'h2100 + 16'(i));
        chk(16'(fifo_word_count), 16'h0003);
        chk(16'(capture_done), 16'h0000);
        disarm();
        drain(3, 16'h2100);
        setup(MODE_A_ONLY, ACT_END_TRACE, 16'h1234, 16'h0000);
        for (int i = 0; i < 10; i++)
            cof(16'h3000 + 16'(i));
        chk(16'(capture_done), 16'h0000);
        access(16'h1234, 8'h00, 8'h00);
        chk(16'(fifo_word_count), 16'h0008);
        chk(16'(capture_done), 16'h0001);
        disarm();
        drain(8, 16'h3002);
        $display("test trace done");
        repeat (300)
        begin
            r = rnd();
            a = r[31:16];
            b = r[4] ? a + 16'(r[8:5]) : 16'(rnd());
            x = r[1:0] == 2'h0 ? a : (r[1:0] == 2'h1 ? b : 16'(rnd()));
            dir_qual_enable_a <= r[2:0] < 3'h5 && r[9];
            dir_select_a <= r[10];
            dir_qual_enable_b <= r[2:0] < 3'h3 && r[11];
            dir_select_b <= r[12];
            serial_debug_access <= r[15:13] == 3'h0;
            req_rw <= r[22];
            brk_seen = 0;
            setup(r[2:0] == 3'h7 ? MODE_A_ONLY : r[2:0], {1'h0, r[3]}, a, b);
            access(x, r[20] ? b[7:0] : 8'(rnd()), r[21] ? b[7:0] : 8'(rnd()));
            chk(16'(fifo_word_count), 16'(hit(x) && r[3]));
            chk(16'(brk_seen), 16'(hit(x) && !r[3]));
            disarm();
            serial_debug_access <= 1'h0;
        end
        $display("test random done");
        stop_test();
    end

    initial
    begin
        tick(20000);
        error_cnt++;
        stop_test();
    end
endmodule // bus_trace_trigger_debug_bench
